/* File: src/mir_pkg.sv */
package mir_pkg;

  // Byte addresses of the indication bank, multi-byte values little-endian
  localparam logic [15:0] ADDR_CAL_CONTROL    = 16'h0202;
  localparam logic [15:0] ADDR_CYCLE_EXPONENT = 16'h0203;
  localparam logic [15:0] ADDR_RAW_CURRENT0   = 16'h0205;
  localparam logic [15:0] ADDR_RAW_CURRENT1   = 16'h0207;
  localparam logic [15:0] ADDR_CURRENT0       = 16'h0209;
  localparam logic [15:0] ADDR_CURRENT1       = 16'h020b;
  localparam logic [15:0] ADDR_SEL_CURRENT    = 16'h020d;
  localparam logic [15:0] ADDR_RAW_VOLTAGE    = 16'h020f;
  localparam logic [15:0] ADDR_VOLTAGE        = 16'h0211;
  localparam logic [15:0] ADDR_LINE_HZ        = 16'h0213;
  localparam logic [15:0] ADDR_TICK_TOTAL     = 16'h0215;
  localparam logic [15:0] ADDR_REAL_WATTS     = 16'h0219;
  localparam logic [15:0] ADDR_VOLT_AMPERE    = 16'h021d;
  localparam logic [15:0] ADDR_PF             = 16'h0221;
  localparam logic [15:0] ADDR_VAR            = 16'h0223;
  localparam logic [15:0] ADDR_TAMPER         = 16'h0227;
  localparam logic [15:0] ADDR_BATTERY        = 16'h0228;

  // Field widths in bytes
  localparam logic [2:0] BYTES_U8  = 3'h1;
  localparam logic [2:0] BYTES_U16 = 3'h2;
  localparam logic [2:0] BYTES_U32 = 3'h4;

  // Calibration control byte layout
  localparam int CTRL_FORCE_BIT = 4;
  localparam int CTRL_PICK_BIT  = 3;
  localparam int CTRL_BASE_BIT  = 1;
  localparam int CTRL_TRIM_BIT  = 0;

  // Tamper byte layout
  localparam int TMP_BATTERY_BIT = 7;
  localparam int TMP_LOG_BIT     = 6;
  localparam int TMP_HZ_BIT      = 5;
  localparam int TMP_SWITCH_BIT  = 4;
  localparam int TMP_MAGNET_BIT  = 3;
  localparam int TMP_CUR1_BIT    = 2;
  localparam int TMP_CUR0_BIT    = 1;
  localparam int TMP_SIGN_BIT    = 0;

  // Reset values
  localparam logic [15:0] EXPONENT_RESET = 16'h0004;
  localparam logic [7:0]  TAMPER_RESET   = 8'h00;

  // Synchroniser idle levels: bit 0 serial line high, bit 1 enclosure switch closed
  localparam logic [1:0] SYNC_IDLE = 2'h1;

  // Largest exponent the line cycle counter can honour
  localparam logic [3:0] EXPONENT_MAX = 4'hf;

  // Line frequency window in 0.01 Hz counts: 45.00 and 65.00 Hz
  localparam logic [15:0] LINE_HZ_MIN = 16'h1194;
  localparam logic [15:0] LINE_HZ_MAX = 16'h1964;

  // Fixed tick total of a measurement cycle, value is a plain default
  localparam logic [31:0] CYCLE_TICK_TOTAL = 32'h0001_0000;

  // Gains carry this many fraction bits, 16'h8000 is unity
  localparam int GAIN_FRAC = 15;

  // Serial link timing
  localparam int CLK_HZ    = 100_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam logic [9:0] BIT_CYCLES  = 10'(CLK_HZ / BAUD_RATE);
  localparam logic [9:0] HALF_CYCLES = 10'(CLK_HZ / BAUD_RATE / 2);

  // Serial commands
  localparam logic [7:0] CMD_READ  = 8'h52;
  localparam logic [7:0] CMD_WRITE = 8'h57;

  // Readings delivered by the metering engine
  typedef struct packed {
    logic [15:0] raw_current0;
    logic [15:0] raw_current1;
    logic [15:0] raw_voltage;
    logic [15:0] line_hz;
    logic [31:0] real_watts;
    logic [31:0] volt_ampere;
    logic [15:0] pf;
    logic [31:0] vars;
    logic [11:0] battery;
  } mir_meas_t;

  // Gains applied to the raw levels
  typedef struct packed {
    logic [15:0] current0;
    logic [15:0] current1;
    logic [15:0] voltage;
  } mir_gain_t;

  // Live tamper sources from same-clock logic
  typedef struct packed {
    logic battery_low;
    logic log_full;
    logic magnetic_field;
    logic sign0_neg;
    logic sign1_neg;
  } mir_tamper_src_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mir_rx_state_t;
  typedef enum logic [2:0] {P_CMD, P_ADDR_HI, P_ADDR_LO, P_DATA, P_SEND} mir_proto_state_t;

endpackage

/* File: src/mir_register_bank.sv */
`timescale 1ns/10ps
module mir_register_bank (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  arst_n_i,
  // Serial link to the calibration device
  input  wire logic                  uart_rx_i,
  output logic                       uart_tx_o,
  // Metering engine
  input  wire logic                  line_cycle_i,
  input  mir_pkg::mir_meas_t         meas_i,
  input  mir_pkg::mir_gain_t         gain_i,
  input  mir_pkg::mir_tamper_src_t   tamper_src_i,
  input  wire logic                  switch_open_i,
  input  wire logic                  baseline_done_i,
  // Control outputs
  output logic                       priority_channel_o,
  output logic                       auto_trim_en_o,
  output logic                       baseline_req_o,
  output logic                       refresh_o,
  output logic [7:0]                 tamper_flags_o
);
  import mir_pkg::*;

  // Reads one byte of a little-endian field, bit 8 flags a hit
  // The size check keeps a field from answering for its neighbour's bytes
  function automatic logic [8:0] rd_field(input logic [15:0] a, input logic [15:0] base,
                                          input logic [2:0] nb, input logic [31:0] v);
    logic [15:0] off;
    logic [31:0] sh;
    off = a - base;
    sh = v >> {off[1:0], 3'h0};
    rd_field = (a >= base && off < {13'h0000, nb}) ? {1'b1, sh[7:0]} : 9'h000;
  endfunction

  // Applies a gain with saturation so a large gain cannot wrap a reading
  // The product is exact in 32 bits, so only its top bit can mark an overflow
  function automatic logic [15:0] gain_apply(input logic [15:0] raw, input logic [15:0] g);
    logic [31:0] p;
    p = {16'h0000, raw} * {16'h0000, g};
    gain_apply = p[31] ? 16'hffff : p[GAIN_FRAC+15:GAIN_FRAC];
  endfunction

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [1:0] pin_raw;
  logic [1:0] pin_f;
  assign pin_raw = {switch_open_i, uart_rx_i};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic s1_q, s2_q, s3_q, f_q;
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          // Each lane resets to its pin's idle level, so no false change follows reset
          s1_q <= SYNC_IDLE[gi];
          s2_q <= SYNC_IDLE[gi];
          s3_q <= SYNC_IDLE[gi];
          f_q  <= SYNC_IDLE[gi];
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // Lane 0 is the serial line, idle high; lane 1 is the enclosure switch, idle closed
  // The switch flag trails the pin by five clocks, far below any tamper that matters
  logic rx_line;
  logic switch_open;
  assign rx_line     = pin_f[0];
  assign switch_open = pin_f[1];

  // Serial receiver, samples mid-bit
  // Leaving at mid stop bit keeps the next start edge in view with no gap
  mir_rx_state_t rx_state_q;
  logic [9:0]    rx_cnt_q;
  logic [2:0]    rx_bit_q;
  logic [7:0]    rx_sh_q;
  logic          rx_valid_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 10'h000;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (rx_cnt_q != 10'h000) begin
        rx_cnt_q <= rx_cnt_q - 10'h001;
      end else begin
        unique case (rx_state_q)
          RX_IDLE: begin
            if (!rx_line) begin
              rx_state_q <= RX_START;
              rx_cnt_q   <= HALF_CYCLES;
            end
          end
          RX_START: begin
            // A start bit gone by mid-bit was a glitch
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_q   <= BIT_CYCLES - 10'h001;
            rx_bit_q   <= 3'h0;
          end
          RX_DATA: begin
            rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            rx_cnt_q <= BIT_CYCLES - 10'h001;
            if (rx_bit_q == 3'h7) begin
              rx_state_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_valid_q <= rx_line;  // Framing error drops the byte
            rx_state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Command framing: command, address high, address low, then data or reply
  // Unknown command bytes are skipped, so line noise opens a frame only when it decodes as a read or write command byte
  mir_proto_state_t p_state_q;
  logic             is_write_q;
  logic [15:0]      addr_q;
  logic             tx_busy;
  logic             tx_load;
  logic             wr_en;
  assign tx_load = (p_state_q == P_SEND) && !tx_busy;
  assign wr_en   = (p_state_q == P_DATA) && rx_valid_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p_state_q  <= P_CMD;
      is_write_q <= 1'b0;
      addr_q     <= 16'h0000;
    end else begin
      unique case (p_state_q)
        P_CMD: begin
          if (rx_valid_q && (rx_sh_q == CMD_READ || rx_sh_q == CMD_WRITE)) begin
            is_write_q <= (rx_sh_q == CMD_WRITE);
            p_state_q  <= P_ADDR_HI;
          end
        end
        P_ADDR_HI: begin
          if (rx_valid_q) begin
            addr_q[15:8] <= rx_sh_q;
            p_state_q    <= P_ADDR_LO;
          end
        end
        P_ADDR_LO: begin
          if (rx_valid_q) begin
            addr_q[7:0] <= rx_sh_q;
            p_state_q   <= is_write_q ? P_DATA : P_SEND;
          end
        end
        P_DATA: begin
          if (rx_valid_q) begin
            p_state_q <= P_CMD;
          end
        end
        P_SEND: begin
          // While a second reply waits for the transmitter, further bytes are lost;
          // a host lets a reply finish before it sends a second read
          if (tx_load) begin
            p_state_q <= P_CMD;
          end
        end
      endcase
    end
  end

  // Write decode; only control and exponent bytes are writable
  // Any other address, read-only indications included, drops the data byte
  logic wr_ctrl, wr_exp_lo, wr_exp_hi;
  assign wr_ctrl   = wr_en && addr_q == ADDR_CAL_CONTROL;
  assign wr_exp_lo = wr_en && addr_q == ADDR_CYCLE_EXPONENT;
  assign wr_exp_hi = wr_en && addr_q == ADDR_CYCLE_EXPONENT + 16'h0001;

  // Calibration control bits, all zero at reset
  // Bit 2 and bits 7-5 have no storage, so they can never read back set
  logic        force_q, pick_q, base_q, trim_q;
  logic [15:0] exp_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      force_q <= 1'b0;
      pick_q  <= 1'b0;
      base_q  <= 1'b0;
      trim_q  <= 1'b0;
      exp_q   <= EXPONENT_RESET;
    end else begin
      if (wr_ctrl) begin
        force_q <= rx_sh_q[CTRL_FORCE_BIT];
        pick_q  <= rx_sh_q[CTRL_PICK_BIT];
        trim_q  <= rx_sh_q[CTRL_TRIM_BIT];
      end
      // A write in the cycle of completion wins over the clear
      base_q <= wr_ctrl ? rx_sh_q[CTRL_BASE_BIT] : (base_q & ~baseline_done_i);
      if (wr_exp_lo) begin
        exp_q[7:0] <= rx_sh_q;
      end
      if (wr_exp_hi) begin
        exp_q[15:8] <= rx_sh_q;
      end
    end
  end

  // Computation cycle end; exponents above the counter width saturate
  // A new exponent does not restart the count; a count already past the
  // new end closes the cycle on the next line pulse
  logic [3:0]  n_eff;
  logic [15:0] line_last;
  logic [15:0] line_cnt_q;
  logic        cycle_end;
  assign n_eff     = (exp_q > {12'h000, EXPONENT_MAX}) ? EXPONENT_MAX : exp_q[3:0];
  assign line_last = 16'((17'h00001 << n_eff) - 17'h00001);
  assign cycle_end = line_cycle_i && line_cnt_q >= line_last;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_cnt_q <= 16'h0000;
    end else if (line_cycle_i) begin
      line_cnt_q <= cycle_end ? 16'h0000 : line_cnt_q + 16'h0001;
    end
  end

  // Indication snapshot, refreshed once per computation cycle
  // Gains act only at refresh, so a gain change shows at the next cycle end
  mir_meas_t   ind_q;
  logic [15:0] cur0_q, cur1_q, volt_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ind_q     <= '0;
      cur0_q    <= 16'h0000;
      cur1_q    <= 16'h0000;
      volt_q    <= 16'h0000;
      refresh_o <= 1'b0;
    end else begin
      refresh_o <= cycle_end;
      if (cycle_end) begin
        ind_q  <= meas_i;
        cur0_q <= gain_apply(meas_i.raw_current0, gain_i.current0);
        cur1_q <= gain_apply(meas_i.raw_current1, gain_i.current1);
        volt_q <= gain_apply(meas_i.raw_voltage, gain_i.voltage);
      end
    end
  end

  // Channel comparison shared by the priority pick and the low-current flags
  logic cur0_lower;
  logic cur1_lower;
  assign cur0_lower = cur0_q < cur1_q;
  assign cur1_lower = cur1_q < cur0_q;

  // Priority channel: forced pick, else the larger calibrated current
  logic prio_d;
  logic sel_chan;
  assign prio_d   = force_q ? pick_q : cur0_lower;
  assign sel_chan = priority_channel_o;

  // Live tamper conditions
  // The frequency flag uses the snapshot, so it reads set until the first refresh
  logic       hz_bad;
  logic [7:0] tamper_d;
  assign hz_bad = ind_q.line_hz < LINE_HZ_MIN || ind_q.line_hz > LINE_HZ_MAX;
  always_comb begin
    tamper_d                  = 8'h00;
    tamper_d[TMP_BATTERY_BIT] = tamper_src_i.battery_low;
    tamper_d[TMP_LOG_BIT]     = tamper_src_i.log_full;
    tamper_d[TMP_HZ_BIT]      = hz_bad;
    tamper_d[TMP_SWITCH_BIT]  = switch_open;
    tamper_d[TMP_MAGNET_BIT]  = tamper_src_i.magnetic_field;
    tamper_d[TMP_CUR1_BIT]    = cur1_lower;
    tamper_d[TMP_CUR0_BIT]    = cur0_lower;
    tamper_d[TMP_SIGN_BIT]    = tamper_src_i.sign0_neg ^ tamper_src_i.sign1_neg;
  end

  // Registered control outputs; flags follow their sources with no latching
  // The priority output also steers the selected level, one clock behind the levels
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      priority_channel_o <= 1'b0;
      auto_trim_en_o     <= 1'b0;
      baseline_req_o     <= 1'b0;
      tamper_flags_o     <= TAMPER_RESET;
    end else begin
      priority_channel_o <= prio_d;
      auto_trim_en_o     <= trim_q;
      baseline_req_o     <= base_q;
      tamper_flags_o     <= tamper_d;
    end
  end

  // Read image; unused control bits stay zero, unmapped bytes read zero
  // Multi-byte reads are not atomic: a refresh between bytes can mix two cycles
  logic [7:0]  ctrl_rd;
  logic [15:0] sel_level;
  logic [8:0]  rd_all;
  assign ctrl_rd   = {3'h0, force_q, pick_q, 1'b0, base_q, trim_q};
  assign sel_level = sel_chan ? cur1_q : cur0_q;
  assign rd_all =
    rd_field(addr_q, ADDR_CAL_CONTROL, BYTES_U8, {24'h000000, ctrl_rd}) |
    rd_field(addr_q, ADDR_CYCLE_EXPONENT, BYTES_U16, {16'h0000, exp_q}) |
    rd_field(addr_q, ADDR_RAW_CURRENT0, BYTES_U16, {16'h0000, ind_q.raw_current0}) |
    rd_field(addr_q, ADDR_RAW_CURRENT1, BYTES_U16, {16'h0000, ind_q.raw_current1}) |
    rd_field(addr_q, ADDR_CURRENT0, BYTES_U16, {16'h0000, cur0_q}) |
    rd_field(addr_q, ADDR_CURRENT1, BYTES_U16, {16'h0000, cur1_q}) |
    rd_field(addr_q, ADDR_SEL_CURRENT, BYTES_U16, {16'h0000, sel_level}) |
    rd_field(addr_q, ADDR_RAW_VOLTAGE, BYTES_U16, {16'h0000, ind_q.raw_voltage}) |
    rd_field(addr_q, ADDR_VOLTAGE, BYTES_U16, {16'h0000, volt_q}) |
    rd_field(addr_q, ADDR_LINE_HZ, BYTES_U16, {16'h0000, ind_q.line_hz}) |
    rd_field(addr_q, ADDR_TICK_TOTAL, BYTES_U32, CYCLE_TICK_TOTAL) |
    rd_field(addr_q, ADDR_REAL_WATTS, BYTES_U32, ind_q.real_watts) |
    rd_field(addr_q, ADDR_VOLT_AMPERE, BYTES_U32, ind_q.volt_ampere) |
    rd_field(addr_q, ADDR_PF, BYTES_U16, {16'h0000, ind_q.pf}) |
    rd_field(addr_q, ADDR_VAR, BYTES_U32, ind_q.vars) |
    rd_field(addr_q, ADDR_TAMPER, BYTES_U8, {24'h000000, tamper_flags_o}) |
    rd_field(addr_q, ADDR_BATTERY, BYTES_U16, {20'h00000, ind_q.battery});

  // Serial transmitter: start bit on load, eight data bits, one stop bit
  // The stop bit counts as busy, so a waiting reply never shortens it
  logic [8:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [9:0] tx_cnt_q;
  assign tx_busy = (tx_left_q != 4'h0) || (tx_cnt_q != 10'h000);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_sh_q   <= 9'h1ff;
      tx_left_q <= 4'h0;
      tx_cnt_q  <= 10'h000;
      uart_tx_o <= 1'b1;
    end else if (tx_load) begin
      tx_sh_q   <= {1'b1, rd_all[7:0]};
      tx_left_q <= 4'h9;
      tx_cnt_q  <= BIT_CYCLES - 10'h001;
      uart_tx_o <= 1'b0;
    end else if (tx_cnt_q != 10'h000) begin
      tx_cnt_q <= tx_cnt_q - 10'h001;
    end else if (tx_left_q != 4'h0) begin
      uart_tx_o <= tx_sh_q[0];
      tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q  <= BIT_CYCLES - 10'h001;
    end
  end

endmodule

/* File: tb/mir_register_bank_chk.sv */
`timescale 1ns/10ps
// Port-level checks on the indication bank
module mir_register_bank_chk
  import mir_pkg::*;
(
  // Clock and reset
  input wire logic                     clock_i,
  input wire logic                     arst_n_i,
  // Observed ports
  input wire logic                     uart_rx_i,
  input wire logic                     uart_tx_o,
  input wire logic                     line_cycle_i,
  input mir_pkg::mir_meas_t            meas_i,
  input mir_pkg::mir_gain_t            gain_i,
  input mir_pkg::mir_tamper_src_t      tamper_src_i,
  input wire logic                     switch_open_i,
  input wire logic                     baseline_done_i,
  input wire logic                     priority_channel_o,
  input wire logic                     auto_trim_en_o,
  input wire logic                     baseline_req_o,
  input wire logic                     refresh_o,
  input wire logic [7:0]               tamper_flags_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  chk_refresh_single: assert property (refresh_o |=> !refresh_o)
    else $error("refresh pulse longer than one cycle");
  chk_refresh_cause: assert property (refresh_o |-> $past(line_cycle_i))
    else $error("refresh without a line cycle pulse");
  chk_sign_flag: assert property (tamper_flags_o[0] == $past(tamper_src_i.sign0_neg ^
      tamper_src_i.sign1_neg)) else $error("power sign flag wrong");
  chk_battery_flag: assert property (tamper_flags_o[7] ==
      $past(tamper_src_i.battery_low)) else $error("battery flag wrong");
  chk_log_flag: assert property (tamper_flags_o[6] == $past(tamper_src_i.log_full))
    else $error("log full flag wrong");
  chk_magnet_flag: assert property (tamper_flags_o[3] ==
      $past(tamper_src_i.magnetic_field)) else $error("magnetic flag wrong");
  chk_chan_exclusive: assert property (tamper_flags_o[2] |-> !tamper_flags_o[1])
    else $error("both current low flags set");
  chk_chan_refresh: assert property ($changed(tamper_flags_o[2:1]) |-> $past(refresh_o))
    else $error("current low flags moved without a refresh");
  chk_switch_flag: assert property ((switch_open_i == $past(switch_open_i))[*6]
      |-> tamper_flags_o[4] == switch_open_i) else $error("switch flag wrong");
  chk_baseline_clear: assert property (baseline_done_i |-> ##[1:2] !baseline_req_o)
    else $error("baseline request not cleared");
endmodule

bind mir_register_bank mir_register_bank_chk chk_u (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .uart_rx_i(uart_rx_i), .uart_tx_o(uart_tx_o),
  .line_cycle_i(line_cycle_i), .meas_i(meas_i), .gain_i(gain_i), .tamper_src_i(tamper_src_i),
  .switch_open_i(switch_open_i), .baseline_done_i(baseline_done_i),
  .priority_channel_o(priority_channel_o), .auto_trim_en_o(auto_trim_en_o),
  .baseline_req_o(baseline_req_o), .refresh_o(refresh_o), .tamper_flags_o(tamper_flags_o)
);

/* File: tb/mir_uart_host.sv */
`timescale 1ns/10ps
// Calibration device on the far side of the serial link
module mir_uart_host
  import mir_pkg::*;
(
  // Clock for bit timing
  input  wire logic clock_i,
  // Serial lines
  output logic      tx_o,
  input  wire logic rx_i
);
  initial tx_o = 1'b1;

  // Start bit, data LSB first, stop bit; line idles high between frames
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_o = frame[i];
      repeat (int'(BIT_CYCLES)) @(negedge clock_i);
    end
  endtask

  // Bounded wait for a start bit so a silent device cannot hang us
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    // A reply starts about one frame after the request's last byte begins
    while (rx_i !== 1'b0 && n < 12 * int'(BIT_CYCLES)) begin
      @(negedge clock_i);
      n++;
    end
    repeat (int'(HALF_CYCLES)) @(negedge clock_i);
    ok = (rx_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (int'(BIT_CYCLES)) @(negedge clock_i);
      b[i] = rx_i;
    end
    repeat (int'(BIT_CYCLES)) @(negedge clock_i);
    ok = ok && (rx_i === 1'b1);
  endtask
endmodule

/* File: tb/test_meter_indication_registers.sv */
`timescale 1ns/10ps
module test_meter_indication_registers;
  import mir_pkg::*;
  logic            clock_i = 1'b0;
  logic            arst_n_i = 1'b0;
  logic            line_cycle = 1'b0;
  logic            switch_open = 1'b0;
  logic            baseline_done = 1'b0;
  mir_meas_t       meas = '0;
  mir_gain_t       gain = '0;
  mir_tamper_src_t tsrc = '0;
  logic            uart_rx, uart_tx, prio, trim, base, refresh;
  logic [7:0]      flags, rd;
  logic            ok;
  logic [15:0]     hz_tab [5] = '{16'h1193, 16'h1194, 16'h1964, 16'h1965, 16'h1388};
  int              fails = 0;
  int              num_checks = 0;
  int              refreshes = 0;

  always #5 clock_i = ~clock_i;

  mir_uart_host host_u (.clock_i(clock_i), .tx_o(uart_rx), .rx_i(uart_tx));

  mir_register_bank dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .uart_rx_i(uart_rx), .uart_tx_o(uart_tx),
    .line_cycle_i(line_cycle), .meas_i(meas), .gain_i(gain), .tamper_src_i(tsrc),
    .switch_open_i(switch_open), .baseline_done_i(baseline_done),
    .priority_channel_o(prio), .auto_trim_en_o(trim), .baseline_req_o(base),
    .refresh_o(refresh), .tamper_flags_o(flags)
  );

  // Sampled away from the launching edge to avoid a race
  always @(negedge clock_i) begin
    if (refresh === 1'b1) refreshes++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Gain has 15 fraction bits; overflow saturates
  function automatic logic [15:0] cal(input logic [15:0] raw, input logic [15:0] g);
    logic [31:0] p;
    p = (32'(raw) * 32'(g)) >> 15;
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction

  function automatic logic [7:0] exp_flags();
    logic [15:0] c0, c1;
    c0 = cal(meas.raw_current0, gain.current0);
    c1 = cal(meas.raw_current1, gain.current1);
    return {tsrc.battery_low, tsrc.log_full,
            (meas.line_hz < 16'h1194) || (meas.line_hz > 16'h1964), switch_open,
            tsrc.magnetic_field, c1 < c0, c0 < c1, tsrc.sign0_neg ^ tsrc.sign1_neg};
  endfunction

  // Random readings, then one full computation cycle of line pulses
  task automatic run_round(input logic [15:0] hz, input logic forced, input logic tie);
    logic [15:0] c0, c1;
    meas = 188'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
    gain = 48'({$urandom, $urandom});
    tsrc = 5'($urandom);
    switch_open = 1'($urandom);
    meas.line_hz = hz;
    if (tie) begin
      meas.raw_current1 = meas.raw_current0;
      gain.current1 = gain.current0;
    end
    refreshes = 0;
    for (int i = 0; i < 16; i++) begin
      line_cycle = 1'b1;
      @(negedge clock_i);
      line_cycle = 1'b0;
      repeat (3) @(negedge clock_i);
    end
    c0 = cal(meas.raw_current0, gain.current0);
    c1 = cal(meas.raw_current1, gain.current1);
    check("refresh count", 32'(refreshes), 32'h1);
    check("tamper flags", 32'(flags), 32'(exp_flags()));
    check("priority", 32'(prio), forced ? 32'h1 : 32'(c1 > c0));
  endtask

  initial begin
    // The main sequence needs about 70,000 cycles
    repeat (85_000) @(negedge clock_i);
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h639a));
    repeat (2) @(negedge clock_i);
    check("reset outputs", 32'({trim, base, prio, flags}), 32'h0);
    arst_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    for (int i = 0; i < 5; i++) run_round(hz_tab[i], 1'b0, i == 4);
    // All ones: unused bits must drop, force and pick both set
    host_u.send_byte(CMD_WRITE);
    host_u.send_byte(ADDR_CAL_CONTROL[15:8]);
    host_u.send_byte(ADDR_CAL_CONTROL[7:0]);
    host_u.send_byte(8'hff);
    repeat (4) @(negedge clock_i);
    check("control outputs", 32'({trim, base, prio}), 32'h7);
    run_round(16'h1194 + 16'($urandom_range(32'h7d0)), 1'b1, 1'b0);
    host_u.send_byte(CMD_READ);
    host_u.send_byte(ADDR_CAL_CONTROL[15:8]);
    fork
      host_u.send_byte(ADDR_CAL_CONTROL[7:0]);
      host_u.recv_byte(rd, ok);
    join
    check("read frame", 32'(ok), 32'h1);
    check("control readback", 32'(rd), 32'h1b);
    baseline_done = 1'b1;
    @(negedge clock_i);
    baseline_done = 1'b0;
    repeat (3) @(negedge clock_i);
    check("baseline cleared", 32'({trim, base}), 32'h2);
    wrap_up();
  end
endmodule
